/* sim/access_partner.sv */
// Far-side model: peripheral registers and external memory
`timescale 1ns/1ps
`default_nettype none
module access_partner (
  input wire logic clk,
  input wire logic periphStrobe,
  input wire logic periphWrite,
  input wire logic [11:0] periphAddr,
  input wire logic [15:0] periphWriteData,
  input wire logic [1:0] periphByteEnable,
  output logic [15:0] periphReadData,
  output logic periphByteReg,
  input wire logic extStrobe,
  input wire logic [21:0] externalAddressLines,
  output logic [31:0] extReadData,
  output logic extDone
);
  logic [15:0] pm [0:2047];
  logic [1:0] dly = 2'h0;
  logic [31:0] img;
  initial for (int i = 0; i < 2048; i++) pm[i] = 16'h0;
  assign periphByteReg = periphAddr[11];
  assign periphReadData = pm[periphAddr[11:1]];
  assign img = {10'h0, externalAddressLines} ^ 32'h5a5a0000;
  assign extReadData = extDone ? img : ~img;
  assign extDone = dly[1];
  always @(posedge clk) begin
    dly <= {dly[0], extStrobe};
    if (periphStrobe && periphWrite && periphByteEnable[0]) pm[periphAddr[11:1]][7:0] <= periphWriteData[7:0];
    if (periphStrobe && periphWrite && periphByteEnable[1]) pm[periphAddr[11:1]][15:8] <= periphWriteData[15:8];
  end
endmodule // access_partner
`default_nettype wire

/* sim/cpu_peripheral_access_decode_chk.sv */
// Assertion checker for the core access decoder
`timescale 1ns/1ps
`default_nettype none
`include "cpu_periph_defs.vh"
module cpu_peripheral_access_decode_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [2:0] waitCycles,
  input wire logic reqValid,
  input wire logic reqFetch,
  input wire logic [1:0] reqSize,
  input wire logic [31:0] reqAddr,
  input wire logic reqReady,
  input wire logic respValid,
  input wire logic respFetchError,
  input wire logic periphStrobe,
  input wire logic [11:0] periphAddr,
  input wire logic extStrobe,
  input wire logic [21:0] externalAddressLines,
  input wire logic returnOpValid,
  input wire logic [1:0] returnSource,
  input wire logic [31:0] interruptReturnPcSave,
  input wire logic [31:0] fatalReturnPcSave,
  input wire logic [31:0] tableCallReturnPcSave,
  input wire logic [31:0] restoredPc,
  input wire logic restoredPcValid
);
  wire take = reqValid && reqReady && clkEnable;
  wire inP = reqAddr[31:12] == `PERIPH_TOP_VALUE;
  wire [31:0] sel = returnSource == 2'h0 ? interruptReturnPcSave :
    returnSource == 2'h1 ? fatalReturnPcSave : tableCallReturnPcSave;
  logic [5:0] cnt;
  logic word, pk;
  logic [21:0] lastA;
  always @(posedge clk) begin
    if (reset) begin
      cnt <= 6'h3f;
    end else if (take) begin
      cnt <= 6'h1;
      word <= reqSize == `SIZE_WORD;
      pk <= inP && !reqFetch;
      lastA <= reqAddr[21:0];
    end else if (clkEnable && cnt != 6'h3f) begin
      cnt <= cnt + 6'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_fetch; take && reqFetch && inP |=> respValid && respFetchError && !periphStrobe; endproperty
  property p_wlo; take && !reqFetch && inP && reqSize == `SIZE_WORD |=> periphStrobe && periphAddr[1:0] == 2'h0;
  endproperty
  property p_whi; periphStrobe && word && cnt > 6'h1 |-> periphAddr[1:0] == 2'h2; endproperty
  property p_htime; respValid && pk && !word |-> cnt == 6'h5 + waitCycles; endproperty
  property p_wtime; respValid && pk && word |-> cnt == 6'h9 + {waitCycles, 1'b0}; endproperty
  property p_mirror; extStrobe |-> externalAddressLines == lastA; endproperty
  property p_even;
    returnOpValid && clkEnable |=> restoredPcValid && restoredPc == ($past(sel) & 32'hfffffffe);
  endproperty
  property p_busy; take && !(reqFetch && inP) |=> !reqReady; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not refused");
  a_wlo: assert property (p_wlo) else $error("word low half wrong");
  a_whi: assert property (p_whi) else $error("word high half wrong");
  a_htime: assert property (p_htime) else $error("half access time wrong");
  a_wtime: assert property (p_wtime) else $error("word access time wrong");
  a_mirror: assert property (p_mirror) else $error("external address wrong");
  a_even: assert property (p_even) else $error("restored pc wrong");
  a_busy: assert property (p_busy) else $error("second request taken");
  c_word: cover property (respValid && pk && word);
  c_fetch: cover property (respFetchError);
  c_ext: cover property (extStrobe);
endmodule // cpu_peripheral_access_decode_chk
bind cpu_peripheral_access_decode cpu_peripheral_access_decode_chk chk (.*);
`default_nettype wire

/* sim/testbench.sv */
// Random and corner tests of the core access decoder
`timescale 1ns/1ps
`default_nettype none
`include "cpu_periph_defs.vh"
module testbench;
  logic clk, reset, clkEnable, reqValid, reqFetch, reqWrite, reqReady, respValid, respFetchError;
  logic periphStrobe, periphWrite, periphByteReg, extStrobe, extWrite, extDone, returnOpValid, restoredPcValid;
  logic [2:0] waitCycles;
  logic [1:0] reqSize, periphByteEnable, extSize, returnSource;
  logic [11:0] periphAddr;
  logic [15:0] periphWriteData, periphReadData, old;
  logic [21:0] externalAddressLines;
  logic [31:0] reqAddr, reqWriteData, respReadData, extWriteData, extReadData, restoredPc;
  logic [31:0] interruptReturnPcSave, fatalReturnPcSave, tableCallReturnPcSave, seed, rd, d, a, h;
  logic fe;
  int bad_count, n_checks;
  cpu_peripheral_access_decode dut (.*);
  access_partner partner (.*);
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] pcExp(input logic [1:0] s);
    return (s == 2'h0 ? interruptReturnPcSave : s == 2'h1 ? fatalReturnPcSave : tableCallReturnPcSave) & ~32'h1;
  endfunction
  task check(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic req(input logic f, w, input logic [1:0] s, input logic [31:0] ad, wd);
    int n;
    @(posedge clk);
    #1;
    {reqValid, reqFetch, reqWrite, reqSize, reqAddr, reqWriteData} = {1'b1, f, w, s, ad, wd};
    @(posedge clk);
    #1;
    reqValid = 0;
    for (n = 0; respValid !== 1'b1 && n < 99; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 99) check(32'h0, 32'h1);
    rd = respReadData;
    fe = respFetchError;
  endtask
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  initial begin
    seed = 32'd5414;
    {reset, clkEnable, reqValid, reqFetch, reqWrite, returnOpValid} = 6'h30;
    {waitCycles, reqSize, returnSource, reqAddr, reqWriteData} = 0;
    {interruptReturnPcSave, fatalReturnPcSave, tableCallReturnPcSave} = 0;
    repeat (4) @(posedge clk);
    #1 reset = 0;
    req(1, 0, `SIZE_WORD, 32'h03fff100, 0);
    check({31'h0, fe}, 32'h1);
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      a = rnd();
      waitCycles = d[2:0];
      req(0, 1, `SIZE_WORD, {20'h03fff, 1'b0, a[10:0]}, d);
      req(0, 0, `SIZE_WORD, {20'h03fff, 1'b0, a[10:2], ~a[1:0]}, 0);
      check(rd, d);
      h = {20'h03fff, 1'b1, a[10:1], 1'b0};
      old = partner.pm[h[11:1]];
      req(0, 1, `SIZE_HALF, h, d);
      check({24'h0, partner.pm[h[11:1]][15:8]}, {24'h0, old[15:8]});
      req(0, 0, `SIZE_HALF, h, 0);
      check(rd, {24'h0, d[7:0]});
      req(0, 0, `SIZE_WORD, a & 32'hfdffffff, 0);
      check(rd, {10'h0, a[21:0]} ^ 32'h5a5a0000);
      check({29'h0, extWrite, extSize}, {29'h0, 1'b0, `SIZE_WORD});
      req(0, 1, `SIZE_HALF, d & 32'hfdffffff, a);
      check(extWriteData, a);
      check({7'h0, extWrite, extSize, externalAddressLines}, {7'h0, 1'b1, `SIZE_HALF, d[21:0]});
      {interruptReturnPcSave, fatalReturnPcSave, tableCallReturnPcSave} = {d | 32'h1, a | 32'h1, ~d | 32'h1};
      returnSource = i[1:0];
      returnOpValid = 1;
      @(posedge clk);
      #1;
      returnOpValid = 0;
      check(restoredPc, pcExp(i[1:0]));
    end
    h = pcExp(returnSource);
    {interruptReturnPcSave, fatalReturnPcSave, tableCallReturnPcSave} = {~a, ~d, a};
    returnSource = 2'h1;
    clkEnable = 0;
    returnOpValid = 1;
    repeat (3) @(posedge clk);
    #1;
    check(restoredPc, h);
    clkEnable = 1;
    @(posedge clk);
    #1;
    returnOpValid = 0;
    check(restoredPc, pcExp(2'h1));
    conclude();
  end
endmodule // testbench
`default_nettype wire

/* src/cpu_periph_defs.vh */
// Address map, sizing and timing constants for the core access decoder
`ifndef CPU_PERIPH_DEFS_VH
`define CPU_PERIPH_DEFS_VH
`define PERIPH_BASE 32'h03fff000
`define PERIPH_LAST 32'h03ffffff
`define PERIPH_TOP_BITS 20
`define PERIPH_TOP_VALUE 20'h03fff
`define EXT_ADDR_LINES 22
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define PERIPH_BASE_CLOCKS 3
`define WAIT_WIDTH 3
`endif

/* src/cpu_peripheral_access_decode.v */
// Core access decoder for peripheral register space and external memory
// Operation
// RQ1: Region 03FFF000H-03FFFFFFH is peripheral space; instruction fetches there are refused.
// RQ2: Word access to peripheral space becomes two halfwords, lower first, address bits 1:0 ignored.
// RQ3: Halfword access to byte register: read upper 8 undefined, write lower 8 only.
// RQ4: Core must not access undefined peripheral addresses; behaviour there is not guaranteed.
// RQ5: External space decodes 22 address lines only, mirroring a 4 MB image.
// RQ6: Interrupt or table-call return clears program counter bit 0.
// RQ7: Peripheral access takes three clocks plus software-set wait cycles.
// RQ8: Split halves go back to back; core sees completion after both.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_periph_defs.vh"
module cpu_peripheral_access_decode (
  input wire clk,
  input wire reset,
  input wire clkEnable,
  input wire [`WAIT_WIDTH-1:0] waitCycles,
  input wire reqValid,
  input wire reqFetch,
  input wire reqWrite,
  input wire [1:0] reqSize,
  input wire [31:0] reqAddr,
  input wire [31:0] reqWriteData,
  output wire reqReady,
  output reg respValid,
  output reg respFetchError,
  output reg [31:0] respReadData,
  output reg periphStrobe,
  output reg periphWrite,
  output reg [11:0] periphAddr,
  output reg [15:0] periphWriteData,
  output reg [1:0] periphByteEnable,
  input wire [15:0] periphReadData,
  input wire periphByteReg,
  output reg extStrobe,
  output reg extWrite,
  output reg [1:0] extSize,
  output reg [`EXT_ADDR_LINES-1:0] externalAddressLines,
  output reg [31:0] extWriteData,
  input wire [31:0] extReadData,
  input wire extDone,
  input wire returnOpValid,
  input wire [1:0] returnSource,
  input wire [31:0] interruptReturnPcSave,
  input wire [31:0] fatalReturnPcSave,
  input wire [31:0] tableCallReturnPcSave,
  output reg [31:0] restoredPc,
  output reg restoredPcValid
);
  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  localparam IDLE = 4'b0001;
  localparam PERLO = 4'b0010;
  localparam PERHI = 4'b0100;
  localparam EXTB = 4'b1000;

  function isPeriph;
    input [31:0] addr;
    begin
      isPeriph = (addr[31:12] == `PERIPH_TOP_VALUE); // RQ1
    end
  endfunction

  reg [3:0] state;
  reg [3:0] next_state;
  reg isWord;
  reg isHalf;
  reg [11:0] baseAddr;
  reg [31:0] wdata;
  reg wr;
  reg [1:0] byteEnableReg;
  wire timerStart;
  wire timerDone;

  assign reqReady = (state == IDLE);
  assign timerStart = periphStrobe;

  always @* begin
    periphByteEnable = periphByteReg ? (byteEnableReg & 2'h1) : byteEnableReg; // RQ3
  end

  periph_access_timer accessTimer (
    .clk(clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .start(timerStart),
    .waitCycles(waitCycles),
    .busy(),
    .done(timerDone)
  );

  always @* begin
    next_state = state;
    case (state)
      IDLE: begin
        if (reqValid && !(reqFetch && isPeriph(reqAddr))) begin
          next_state = isPeriph(reqAddr) ? PERLO : EXTB;
        end
      end
      PERLO: begin
        if (timerDone) begin
          next_state = isWord ? PERHI : IDLE; // RQ8
        end
      end
      PERHI: begin
        if (timerDone) begin
          next_state = IDLE;
        end
      end
      EXTB: begin
        if (extDone) begin
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Transfer sequencing
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      state <= IDLE;
      isWord <= 1'b0;
      isHalf <= 1'b0;
      baseAddr <= 12'h000;
      wdata <= 32'h00000000;
      wr <= 1'b0;
      respValid <= 1'b0;
      respFetchError <= 1'b0;
      respReadData <= 32'h00000000;
      periphStrobe <= 1'b0;
      periphWrite <= 1'b0;
      periphAddr <= 12'h000;
      periphWriteData <= 16'h0000;
      byteEnableReg <= 2'h0;
      extStrobe <= 1'b0;
      extWrite <= 1'b0;
      extSize <= 2'h0;
      externalAddressLines <= {`EXT_ADDR_LINES{1'b0}};
      extWriteData <= 32'h00000000;
    end else if (clkEnable) begin
      state <= next_state;
      respValid <= 1'b0;
      respFetchError <= 1'b0;
      periphStrobe <= 1'b0;
      extStrobe <= 1'b0;
      case (state)
        IDLE: begin
          if (reqValid) begin
            isWord <= (reqSize == `SIZE_WORD);
            isHalf <= (reqSize == `SIZE_HALF);
            wdata <= reqWriteData;
            wr <= reqWrite;
            if (reqFetch && isPeriph(reqAddr)) begin
              respValid <= 1'b1; // RQ1
              respFetchError <= 1'b1; // RQ1
              respReadData <= 32'h00000000;
            end else if (isPeriph(reqAddr)) begin
              // Word: drop address bits 1:0, lower half first
              baseAddr <= (reqSize == `SIZE_WORD) ? {reqAddr[11:2], 2'h0} : reqAddr[11:0]; // RQ2
              periphStrobe <= 1'b1;
              periphWrite <= reqWrite;
              periphAddr <= (reqSize == `SIZE_WORD) ? {reqAddr[11:2], 2'h0} : reqAddr[11:0]; // RQ2
              periphWriteData <= reqWriteData[15:0];
              byteEnableReg <= (reqSize == `SIZE_BYTE) ? 2'h1 : 2'h3;
            end else begin
              extStrobe <= 1'b1;
              extWrite <= reqWrite;
              extSize <= reqSize;
              externalAddressLines <= reqAddr[`EXT_ADDR_LINES-1:0]; // RQ5
              extWriteData <= reqWriteData;
            end
          end
        end
        PERLO: begin
          if (timerDone) begin
            respReadData[15:0] <= periphReadData;
            if (periphByteReg && !wr && isHalf) begin
              respReadData[15:8] <= 8'h00; // RQ3
            end
            if (isWord) begin
              periphStrobe <= 1'b1; // RQ8
              periphAddr <= baseAddr + 12'h002; // RQ2
              periphWriteData <= wdata[31:16]; // RQ2
              byteEnableReg <= 2'h3;
            end else begin
              respValid <= 1'b1;
              respReadData[31:16] <= 16'h0000;
            end
          end
        end
        PERHI: begin
          if (timerDone) begin
            respReadData[31:16] <= periphReadData;
            respValid <= 1'b1; // RQ8
          end
        end
        EXTB: begin
          if (extDone) begin
            respReadData <= extReadData;
            respValid <= 1'b1;
          end
        end
        default: begin
          respValid <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Return address restore
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      restoredPc <= 32'h00000000;
      restoredPcValid <= 1'b0;
    end else if (clkEnable) begin
      restoredPcValid <= returnOpValid;
      if (returnOpValid) begin
        case (returnSource)
          2'h0: restoredPc <= {interruptReturnPcSave[31:1], 1'b0}; // RQ6
          2'h1: restoredPc <= {fatalReturnPcSave[31:1], 1'b0}; // RQ6
          default: restoredPc <= {tableCallReturnPcSave[31:1], 1'b0}; // RQ6
        endcase
      end
    end
  end
endmodule // cpu_peripheral_access_decode
`default_nettype wire

/* src/periph_access_timer.v */
// Times one peripheral halfword access: base clocks plus wait cycles
`timescale 1ns/1ps
`default_nettype none
`include "cpu_periph_defs.vh"
module periph_access_timer (
  input wire clk,
  input wire reset,
  input wire clkEnable,
  input wire start,
  input wire [`WAIT_WIDTH-1:0] waitCycles,
  output reg busy,
  output wire done
);
  reg [`WAIT_WIDTH+1:0] count;
  localparam integer BASE_LESS_ONE = `PERIPH_BASE_CLOCKS - 1;

  assign done = busy && (count == {(`WAIT_WIDTH+2){1'b0}});

  always @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      count <= {(`WAIT_WIDTH+2){1'b0}};
    end else if (clkEnable) begin
      if (start && !busy) begin
        busy <= 1'b1;
        count <= BASE_LESS_ONE[`WAIT_WIDTH+1:0] + {2'h0, waitCycles}; // RQ7
      end else if (done) begin
        busy <= 1'b0;
      end else if (busy) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // periph_access_timer
`default_nettype wire
